/* sesa_chk.sv */
`timescale 1ns/100ps
// ==========================================
// Port checks, serial memory front end
module sesa_chk #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_si,
  input wire logic       i_wp_n,
  input wire logic       o_so,
  input wire logic       o_so_oe_n,
  input wire logic       o_write_busy,
  input wire logic       o_write_latch,
  input wire logic [7:0] o_lock_status
);
  logic [31:0] busy_len;

  // Busy run length, zero when idle
  always_ff @(posedge i_ref_clk) begin
    busy_len <= o_write_busy ? busy_len + 32'h1 : 32'h0;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_so_released: assert property (i_cs_n |-> o_so_oe_n && !o_so)
    else $error("so active while deselected");
  chk_so_on_fall: assert property (!i_cs_n && $changed(o_so) |-> !i_sck)
    else $error("so moved with sck high");
  chk_pad_zero: assert property (o_lock_status[7:3] == 5'h00)
    else $error("status pad not zero");
  chk_latch_end: assert property ($fell(o_write_busy) |-> ##[0:2] !o_write_latch)
    else $error("latch kept after write");
  chk_busy_cause: assert property ($rose(o_write_busy) |-> $past(o_write_latch) && i_cs_n)
    else $error("write began without latch");
  chk_lock_commit: assert property ($changed(o_lock_status) |-> ##[0:2] o_write_busy)
    else $error("lock moved outside commit");
  chk_latch_set: assert property ($rose(o_write_latch) |-> i_cs_n && !o_write_busy)
    else $error("latch set mid frame");
  chk_busy_len: assert property ($fell(o_write_busy) |->
      busy_len >= WRITE_CYCLES && busy_len <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
endmodule

/* sesa_host.sv */
`timescale 1ns/100ps
// ==========================================
// Host controller model, mode 0, 32 ns clock
module sesa_host (
  input  wire logic i_so,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si
);
  int gap = 0;

  // Clock idles low, line idles inverted
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b1;
  end

  task automatic frame(input logic [7:0] tx[$], input int nlast, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    #3 o_cs_n = 1'b0;
    #40;
    foreach (tx[k]) begin
      b = 8'h00;
      for (int i = 7; i >= 0; i--) begin
        if (k == tx.size() - 1 && 7 - i >= nlast) break;
        if (i == 3) #(gap);
        o_si = tx[k][i];
        #16;
        b[i] = i_so;
        o_sck = 1'b1;
        #16 o_sck = 1'b0;
      end
      rx.push_back(b);
    end
    #16 o_cs_n = 1'b1;
    o_si = ~o_si;
    #80;
  endtask
endmodule

/* sesa_pkg.sv */
package sesa_pkg;
  // ==========================================================
  // Array geometry
  localparam int MEM_BYTES  = 1024;
  localparam int ADDR_W     = 10;
  localparam int PTR_W      = 4;
  localparam int PAGE_BYTES = 16;
  localparam int BASE_W     = ADDR_W - PTR_W;
  localparam int LOCK_W     = 3;
  localparam int PAD_W      = 8 - LOCK_W;

  // ==========================================================
  // Opcodes, sent MSB first
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_WRITE     = 8'h02;
  localparam logic [7:0] OP_STATUS    = 8'h05;
  localparam logic [7:0] OP_LOCK      = 8'h01;

  // ==========================================================
  // Bit and byte counters
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] ADR_LAST  = 2'h1;
  localparam logic [2:0] BIT_ONE   = 3'h1;
  localparam logic [1:0] NB_ONE    = 2'h1;
  localparam logic [3:0] PTR_ONE   = 4'h1;
  localparam logic [9:0] ADR_ONE   = 10'h001;

  // ==========================================================
  // Self-timed write cycle
  localparam int T_WRITE_US   = 5000;
  localparam int CLK_MHZ      = 125;
  localparam int WRITE_CYCLES = T_WRITE_US * CLK_MHZ;
  localparam int TMR_W        = 20;
  localparam logic [19:0] TMR_ONE = 20'h00001;

  // ==========================================================
  // Lock regions, index is the lock select code; code 0 never matches
  localparam logic [7:0][9:0] LOCK_LO = {10'h3F0, 10'h000, 10'h000, 10'h300,
                                         10'h200, 10'h100, 10'h000, 10'h3FF};
  localparam logic [7:0][9:0] LOCK_HI = {10'h3FF, 10'h00F, 10'h1FF, 10'h3FF,
                                         10'h2FF, 10'h1FF, 10'h0FF, 10'h000};

  typedef enum logic [2:0] {
    PH_CMD   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_WDATA = 3'b010,
    PH_RDATA = 3'b011,
    PH_STAT  = 3'b100,
    PH_LOCK  = 3'b101,
    PH_IGN   = 3'b110
  } sesa_phase_t;

  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_SET   = 3'b001,
    K_CLR   = 3'b010,
    K_WRITE = 3'b011,
    K_LOCK  = 3'b100
  } sesa_kind_t;

  // Link-side state, clocked by the serial clock
  typedef struct packed {
    sesa_phase_t            phase;
    sesa_kind_t             kind;
    logic [2:0]             bitn;
    logic [1:0]             nb;
    logic                   rd;
    logic [15:0]            sr;
    logic [ADDR_W-1:0]      addr;
    logic [PTR_W-1:0]       ptr;
    logic [BASE_W-1:0]      base;
    logic [PAGE_BYTES-1:0]  valid;
    logic [15:0][7:0]       pbuf;
    logic [7:0]             out;
    logic [LOCK_W-1:0]      lockv;
    logic                   busy_m;
    logic                   busy_s;
  } sesa_link_t;

  // Core-side state, clocked by the reference clock
  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic              cs_d;
    logic              wp_m;
    logic              wp_s;
    logic              frame_ok;
    logic              abort;
    logic              wel;
    logic              busy;
    logic [LOCK_W-1:0] lock;
    logic [TMR_W-1:0]  tmr;
  } sesa_core_t;

  function automatic logic sesa_locked(input logic [9:0] a, input logic [2:0] sel);
    sesa_locked = (a >= LOCK_LO[sel]) && (a <= LOCK_HI[sel]);
  endfunction
endpackage

/* sesa_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - Sample on SCK rise, drive after fall
// - CS high deselects, output tristated
// - Nothing accepted before first CS fall
// - WP low blocks all nonvolatile writes
// - WP fall in frame aborts write
// - Eight-bit opcode, everything MSB first
// - Host keeps CS low, WP high
// - Stopped clock resumes where it paused
// - Latch set and cleared by opcodes
// - Latch cleared at reset, write end
// - Extra bits after set-latch void it
// - Seven lock regions refuse writes
// - Lock byte stored until next lock
// - Status byte: lock bits, zero pad
// - Read: opcode plus ten-bit address
// - Read streams, address wraps at top
// - Status read returns lock byte
// - Busy status read drives output high
// - Busy status read still advances pointer
// - Write: opcode, address, data bytes
// - Page of sixteen, pointer wraps
// - Write starts only at byte boundary
// - Latch opcodes 06h and 04h
// - Read 03h, write 02h, status 05h
// - Lock commits at CS rise, last wins
module sesa_top #(
  parameter int WRITE_CYCLES = sesa_pkg::WRITE_CYCLES
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe_n,
  output logic            o_write_busy,
  output logic            o_write_latch,
  output logic [7:0]      o_lock_status
);

  // ==========================================================
  // Storage and state
  // The array has no reset; a byte reads unknown until written
  // State l runs on the serial clock, r on the reference clock
  // The frame marker and SO flop sit apart: they reset on CS
  logic [7:0]          mem [sesa_pkg::MEM_BYTES];
  sesa_pkg::sesa_link_t l;
  sesa_pkg::sesa_link_t next_l;
  sesa_pkg::sesa_core_t r;
  sesa_pkg::sesa_core_t next_r;
  logic                in_frame;
  logic                so_q;
  logic                do_mem;

  // ==========================================================
  // Link domain: frame marker
  // Cleared by CS alone, so no SCK edge is needed after a frame
  // Set on the first SCK rise; a stopped SCK just holds it
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // ==========================================================
  // Link domain: command decoder and shifters
  // Phases: opcode, address, write data, read data, status,
  // lock byte, and an ignore phase for whatever follows.
  // The kind field holds what a CS rise would commit; the core
  // reads it only once CS has risen and SCK has gone quiet.
  // No reset here: the first SCK rise of a frame restarts it.
  always_comb begin
    sesa_pkg::sesa_link_t b;
    b = l;
    if (!in_frame) begin
      // First edge of a frame restarts the decoder
      b.phase = sesa_pkg::PH_CMD;
      b.kind  = sesa_pkg::K_NONE;
      b.bitn  = sesa_pkg::BIT_FIRST;
      b.nb    = 2'h0;
      b.valid = '0;
    end
    next_l = b;
    // Busy crosses into the serial clock through two flops;
    // it is only refreshed while SCK runs, which is all SO needs
    next_l.busy_m = r.busy;
    next_l.busy_s = l.busy_m;
    next_l.sr   = {b.sr[14:0], i_si};
    // State advances only on clock edges
    next_l.bitn = b.bitn + sesa_pkg::BIT_ONE;
    if (b.bitn == sesa_pkg::BIT_LAST) begin
      case (b.phase)
        sesa_pkg::PH_CMD: begin
          // Opcode is whole once its eighth bit is shifted in
          case (next_l.sr[7:0])
            sesa_pkg::OP_SET_LATCH: begin
              next_l.kind  = sesa_pkg::K_SET;
              next_l.phase = sesa_pkg::PH_IGN;
            end
            sesa_pkg::OP_CLR_LATCH: begin
              next_l.kind  = sesa_pkg::K_CLR;
              next_l.phase = sesa_pkg::PH_IGN;
            end
            sesa_pkg::OP_READ: begin
              next_l.rd    = 1'b1;
              next_l.phase = sesa_pkg::PH_ADDR;
            end
            sesa_pkg::OP_WRITE: begin
              next_l.rd    = 1'b0;
              next_l.phase = sesa_pkg::PH_ADDR;
            end
            sesa_pkg::OP_STATUS: begin
              next_l.out   = {{sesa_pkg::PAD_W{1'b0}}, r.lock};
              next_l.phase = sesa_pkg::PH_STAT;
            end
            sesa_pkg::OP_LOCK: begin
              next_l.phase = sesa_pkg::PH_LOCK;
            end
            default: begin
              next_l.phase = sesa_pkg::PH_IGN;
            end
          endcase
        end
        sesa_pkg::PH_ADDR: begin
          next_l.nb = b.nb + sesa_pkg::NB_ONE;
          if (b.nb == sesa_pkg::ADR_LAST) begin
            // Upper address bits dropped
            // Only ten bits are kept, so bits 15 to 10 never matter
            next_l.addr = next_l.sr[sesa_pkg::ADDR_W-1:0];
            next_l.ptr  = next_l.sr[sesa_pkg::PTR_W-1:0];
            next_l.base = next_l.sr[sesa_pkg::ADDR_W-1:sesa_pkg::PTR_W];
            if (b.rd) begin
              next_l.out   = mem[next_l.sr[sesa_pkg::ADDR_W-1:0]];
              next_l.phase = sesa_pkg::PH_RDATA;
            end else begin
              next_l.phase = sesa_pkg::PH_WDATA;
            end
          end
        end
        sesa_pkg::PH_WDATA: begin
          // Page buffer with wrapping pointer
          // A second byte for the same slot overwrites the first
          next_l.pbuf[b.ptr]  = next_l.sr[7:0];
          next_l.valid[b.ptr] = 1'b1;
          next_l.ptr          = b.ptr + sesa_pkg::PTR_ONE;
          // Complete data byte makes a write
          next_l.kind         = sesa_pkg::K_WRITE;
        end
        sesa_pkg::PH_RDATA: begin
          // Natural wrap from top to zero
          // Next byte is fetched as the last bit of this one is taken
          next_l.addr = b.addr + sesa_pkg::ADR_ONE;
          next_l.out  = mem[b.addr + sesa_pkg::ADR_ONE];
        end
        sesa_pkg::PH_STAT: begin
          // Pointer runs even while busy
          // Status byte reloads every eight bits of the frame
          next_l.out = {{sesa_pkg::PAD_W{1'b0}}, r.lock};
        end
        sesa_pkg::PH_LOCK: begin
          // Latest lock byte wins
          // Only the select bits are kept; pad bits are dropped
          next_l.lockv = next_l.sr[sesa_pkg::LOCK_W-1:0];
          next_l.kind  = sesa_pkg::K_LOCK;
        end
        default: begin
          // Ignore phase and stray bytes commit nothing
          next_l.kind = sesa_pkg::K_NONE;
        end
      endcase
    end else if (b.phase == sesa_pkg::PH_IGN) begin
      // Bits after a latch opcode void it
      next_l.kind = sesa_pkg::K_NONE;
    end
  end

  // Inputs taken on the rising edge
  always_ff @(posedge i_sck) begin
    l <= next_l;
  end

  // ==========================================================
  // Link domain: serial output
  // Reset by CS so the pin rests low between frames
  // Output changes on the falling edge
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_q <= 1'b0;
    end else if (l.phase == sesa_pkg::PH_STAT && l.busy_s) begin
      // Busy shows as a high level
      so_q <= 1'b1;
    end else begin
      // Status or array byte, MSB first
      so_q <= l.out[sesa_pkg::BIT_LAST - l.bitn];
    end
  end

  // Opcode and address bits never turn the driver on
  // Frames the core has not accepted keep the pin released
  // Tristate unless selected and sending
  assign o_so      = so_q;
  assign o_so_oe_n = i_cs_n | ~in_frame | ~r.frame_ok |
                     ~(l.phase == sesa_pkg::PH_RDATA || l.phase == sesa_pkg::PH_STAT);

  // ==========================================================
  // Core domain: frame tracking, latch, lock and write timer
  // Link fields are read only after CS rises, while SCK is quiet
  // Trade-off: CS passes three flops so both of its edges are seen
  // cleanly; a frame therefore takes effect a few cycles after CS
  // rises, and the quiet link state needs no handshake then.
  // Limitation: the host must keep CS high for at least four
  // reference cycles between frames, or a frame may be missed.
  always_comb begin
    logic fall;
    logic rise;
    logic commit;
    logic wr_ok;
    fall   = 1'b0;
    rise   = 1'b0;
    commit = 1'b0;
    wr_ok  = 1'b0;
    next_r = r;
    do_mem = 1'b0;
    // Two flops per pin; the third CS flop gives the edge history.
    // It resets low, so the first CS high after reset looks like a
    // rise; frame_ok is still clear then, so it commits nothing.
    next_r.cs_m = i_cs_n;
    next_r.cs_s = r.cs_m;
    next_r.cs_d = r.cs_s;
    next_r.wp_m = i_wp_n;
    next_r.wp_s = r.wp_m;
    fall   = r.cs_d & ~r.cs_s;
    rise   = ~r.cs_d & r.cs_s;
    // Nothing commits while busy, so set and clear never meet
    // Only a byte-aligned end commits
    commit = rise & r.frame_ok & ~r.busy & (l.bitn == sesa_pkg::BIT_FIRST);
    wr_ok  = r.wel & r.wp_s & ~r.abort;
    // Frames count only after a seen fall
    if (fall) begin
      next_r.frame_ok = 1'b1;
      next_r.abort    = 1'b0;
    end
    // A rise closes the frame whatever phase it was in
    if (rise) begin
      next_r.frame_ok = 1'b0;
    end
    // Write or lock valid only with WP high while CS is low
    // Protect fall inside a frame aborts
    // Set wins over the clear at CS fall in the same cycle
    if (!r.cs_s && !r.wp_s) begin
      next_r.abort = 1'b1;
    end
    if (commit) begin
      case (l.kind)
        // Latch opcodes act at CS rise
        sesa_pkg::K_SET: begin
          next_r.wel = 1'b1;
        end
        sesa_pkg::K_CLR: begin
          next_r.wel = 1'b0;
        end
        sesa_pkg::K_WRITE: begin
          // No cycle without the latch
          // Memory update and busy start in the same cycle
          if (wr_ok) begin
            next_r.busy = 1'b1;
            next_r.tmr  = '0;
            do_mem      = 1'b1;
          end
        end
        sesa_pkg::K_LOCK: begin
          // Lock byte kept until next lock
          // The link sees the new lock only through status reads
          if (wr_ok) begin
            next_r.busy = 1'b1;
            next_r.tmr  = '0;
            next_r.lock = l.lockv;
          end
        end
        default: begin
          next_r.wel = r.wel;
        end
      endcase
    end
    // Timer counts reference cycles; its width covers the default
    // Write protect is not looked at here once a cycle has begun
    // A started cycle runs to its end
    if (r.busy) begin
      if (r.tmr == sesa_pkg::TMR_W'(WRITE_CYCLES - 1)) begin
        next_r.busy = 1'b0;
        // Latch drops when the cycle ends
        next_r.wel  = 1'b0;
      end else begin
        next_r.tmr = r.tmr + sesa_pkg::TMR_ONE;
      end
    end
  end

  // ==========================================================
  // Core registers
  // The array and the link state are left as they are
  // Reset clears latch and busy
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Array update at commit; data visible before the timer ends
  // Bytes at locked addresses are skipped, the rest still land
  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < sesa_pkg::PAGE_BYTES; i++) begin
      if (do_mem && l.valid[i] &&
          !sesa_pkg::sesa_locked({l.base, sesa_pkg::PTR_W'(i)}, r.lock)) begin
        mem[{l.base, sesa_pkg::PTR_W'(i)}] <= l.pbuf[i];
      end
    end
  end

  // ==========================================================
  // Status outputs, straight from core registers
  // No synchroniser needed: these are reference-clock flops
  assign o_write_busy  = r.busy;
  assign o_write_latch = r.wel;
  assign o_lock_status = {{sesa_pkg::PAD_W{1'b0}}, r.lock};

endmodule

/* tb.sv */
`timescale 1ns/100ps
// ==========================================
// Self-checking bench
module tb;
  logic       i_ref_clk;
  logic       i_rst;
  logic       i_sck;
  logic       i_cs_n;
  logic       i_si;
  logic       i_wp_n;
  logic       o_so;
  logic       o_so_oe_n;
  logic       o_write_busy;
  logic       o_write_latch;
  logic [7:0] o_lock_status;
  logic [7:0] r[$];
  int         fail_count = 0;
  int         n_checks = 0;

  // Reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  sesa_top #(.WRITE_CYCLES(200)) u_sesa_top (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
    .o_write_busy(o_write_busy), .o_write_latch(o_write_latch),
    .o_lock_status(o_lock_status));

  // A released SO shows the inverse, so reads need the driver on
  sesa_host u_sesa_host (.i_so(o_so_oe_n ? ~o_so : o_so), .o_sck(i_sck), .o_cs_n(i_cs_n),
    .o_si(i_si));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One frame, then time for the core to react
  task automatic cmd(input logic [7:0] b[$], input int nl = 8);
    u_sesa_host.frame(b, nl, r);
    repeat (8) @(negedge i_ref_clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d[$], input int nl = 8);
    cmd({8'h02, 8'(a[9:8]), a[7:0], d}, nl);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] e[$]);
    logic [7:0] q[$];
    q = {8'h03, 8'(a[9:8]), a[7:0]};
    foreach (e[k]) q.push_back(8'h00);
    cmd(q);
    foreach (e[k]) chk(r[k + 3], e[k]);
  endtask

  // Bounded wait for the self-timed cycle
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && o_write_busy !== 1'b0; n++) @(negedge i_ref_clk);
    if (n == 1000) begin
      fail_count++;
      tally_and_finish();
    end
    repeat (4) @(negedge i_ref_clk);
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_wp_n = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk({o_write_busy, o_write_latch}, 8'h00);
    chk(o_lock_status, 8'h00);
    wr(10'h010, {8'h5A});
    chk(o_write_busy, 8'h00);
    cmd({8'h06});
    chk(o_write_latch, 8'h01);
    cmd({8'h04});
    chk(o_write_latch, 8'h00);
    cmd({8'h06, 8'h00});
    chk(o_write_latch, 8'h00);
    cmd({8'h06});
    wr(10'h01E, {8'hA1, 8'hA2, 8'hA3});
    chk(o_write_busy, 8'h01);
    cmd({8'h05, 8'h00, 8'h00});
    chk(r[1], 8'hFF);
    chk(r[2], 8'hFF);
    wait_idle();
    chk(o_write_latch, 8'h00);
    rdchk(10'h01E, {8'hA1, 8'hA2});
    rdchk(10'h010, {8'hA3});
    // Cut short inside a byte, then a protect pulse mid frame
    cmd({8'h06});
    wr(10'h020, {8'h55}, 4);
    chk(o_write_busy, 8'h00);
    fork
      wr(10'h020, {8'h66});
      begin
        #200;
        @(negedge i_ref_clk) i_wp_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        i_wp_n = 1'b1;
      end
    join
    chk(o_write_busy, 8'h00);
    wr(10'h020, {8'h55});
    // Protect falls after the cycle has started
    i_wp_n = 1'b0;
    chk(o_write_busy, 8'h01);
    wait_idle();
    rdchk(10'h020, {8'h55});
    cmd({8'h06});
    wr(10'h020, {8'h77});
    chk(o_write_busy, 8'h00);
    rdchk(10'h020, {8'h55});
    i_wp_n = 1'b1;
    cmd({8'h06});
    wr(10'h3FF, {8'hC1});
    wait_idle();
    cmd({8'h06});
    wr(10'h000, {8'hC2});
    wait_idle();
    u_sesa_host.gap = 150;
    rdchk(10'h3FF, {8'hC1, 8'hC2});
    u_sesa_host.gap = 0;
    // Every lock code, later byte replaces earlier
    for (int c = 0; c < 8; c++) begin
      cmd({8'h06});
      cmd({8'h01, 8'h07, 8'(c)});
      wait_idle();
      chk(o_lock_status, 8'(c));
    end
    cmd({8'h05, 8'h00});
    chk(r[1], 8'h07);
    cmd({8'h06});
    wr(10'h3FF, {8'hEE});
    wait_idle();
    rdchk(10'h3FF, {8'hC1});
    tally_and_finish();
  end
endmodule

bind sesa_top sesa_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_sesa_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
  .o_write_busy(o_write_busy), .o_write_latch(o_write_latch),
  .o_lock_status(o_lock_status));
